// File: inc/vpic_pkg.sv
// Purpose: Shared constants for the vectored priority interrupt controller
// Assumes: APB byte addresses, 32-bit data, registers in the low 16 bits
// Notes:   Notes on behaviour listed below
//
// Notes on behaviour
// - Each source has a flag; the source sets it, only software clears it.
// - One enable bit per source; a cleared enable blocks that source's request.
// - Each user source has a 3-bit priority, one of eight levels.
// - Pending status latches an 8-bit vector number and 4-bit new level.
// - Sources fill flag, enable, priority in list order; IRQ 0 is vector 8.
// - IRQ 84, vector 0BCh, flag/enable reg 5 bit 4, priority reg 21 bits 2:0.
// - IRQ 85, vector 0BEh, flag/enable reg 5 bit 5, priority reg 21 bits 6:4.
// - IRQ 90 at 0C8h and IRQ 91 at 0CAh, flags reg 5 bits 10, 11.
// - IRQ 94 at 0D0h and IRQ 95 at 0D2h, flags reg 5 bits 14, 15.
// - IRQ 96 at 0D4h and IRQ 97 at 0D6h, flags reg 6 bits 0, 1.
// - IRQ 101 at 0DEh and IRQ 102 at 0E0h, flags reg 6 bits 5, 6.
// - IRQ 106 at 0E8h; IRQ 108 at 0ECh with flag reg 6 bit 12.
// - IRQ 110 at 0F0h; IRQ 117 at 0FEh with flag reg 7 bit 5.
// - Trap control register holds nesting disable and the trap status flags.
// - Hard trap status holds software hard trap and double-bit error flags.
// - Status word bits 7:5 hold the low level bits; software may write them.
// - High level bit in core control: software writes can clear it but never set it.
// - Low field codes levels 0..7; with high bit set, levels 8..15.
// - All user interrupts blocked while the low level field is 111.
// - All user interrupts blocked while the high level bit is set.
// - Low level bits are read-only while nesting disable is 1.
// - Nesting disabled: no new interrupt preempts one in service.
// - Global enable cleared suppresses interrupts; traps still taken.
// - External input edge select: 1 falling edge, 0 rising edge.
package vpic_pkg;
  localparam int NUM_IRQ   = 128;
  localparam int FLAG_REGS = 8;
  localparam int PRI_REGS  = 30;
  localparam int PRI_W     = 3;
  localparam int LVL_W     = 4;
  localparam int IDX_W     = 7;

  typedef logic [11:0] vpic_addr_t;
  localparam vpic_addr_t FLAG_OFF = 12'h000;
  localparam vpic_addr_t EN_OFF   = 12'h040;
  localparam vpic_addr_t PRI_OFF  = 12'h080;
  localparam vpic_addr_t TNC_OFF  = 12'h100;
  localparam vpic_addr_t GIC_OFF  = 12'h104;
  localparam vpic_addr_t HTS_OFF  = 12'h108;
  localparam vpic_addr_t PVS_OFF  = 12'h10C;
  localparam vpic_addr_t CSW_OFF  = 12'h110;
  localparam vpic_addr_t CORE_OFF = 12'h114;

  localparam int NEST_DIS_BIT = 15;
  localparam int TRAP_LSB     = 1;
  localparam int TRAP_W       = 4;
  localparam int GIE_BIT      = 15;
  localparam int ALTERNATE_VECTOR_TABLE_BIT     = 8;
  localparam int EDGE_W       = 5;
  localparam int LVL_LSB      = 5;
  localparam int LVL_HIGH_BIT = 3;
  localparam int CPUIRQ_BIT   = 15;
  localparam int VHOLD_BIT    = 13;
  localparam int NEWLVL_LSB   = 8;
  localparam int HTRAP_W      = 2;

  localparam logic [PRI_W-1:0] LVL_TOP   = 3'h7;
  localparam logic [15:0]      GIC_RESET = 16'h8000;
  localparam logic [23:0]      VEC_BASE  = 24'h000014;
  localparam logic [7:0]       PENDING_VECTOR_NUMBER_OFS = 8'h08;
  localparam logic [NUM_IRQ-1:0] VALID_MASK = 128'h00205463_CC300000_00000000_00000001;
endpackage

// File: inc/vpic_win_if.sv
// Purpose: Carries the arbitration winner to the controller
// Assumes: Single clock domain
// Notes:   Combinational result
`timescale 1ns/1ps
interface vpic_win_if;
  import vpic_pkg::*;
  logic                 valid;
  logic [IDX_W-1:0]     idx;
  logic [PRI_W-1:0]     prio;
  modport arb (output valid, idx, prio);
  modport ctl (input valid, idx, prio);
endinterface

// File: rtl/vpic_arbiter.sv
// Purpose: Picks the highest priority active source
// Assumes: Same clock as controller
// Notes:   Ties go to the lower index
`timescale 1ns/1ps
module vpic_arbiter (
  // Clock and reset
  input  wire logic                                     pclk,
  input  wire logic                                     presetn,
  // Sources
  input  wire logic [vpic_pkg::NUM_IRQ-1:0]             active,
  input  wire logic [vpic_pkg::NUM_IRQ-1:0][vpic_pkg::PRI_W-1:0] pri,
  // Winner
  vpic_win_if.arb                                       win
);
  import vpic_pkg::*;

  always_comb begin
    win.valid = 1'b0;
    win.idx   = '0;
    win.prio  = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (active[i] && (!win.valid || pri[i] >= win.prio)) begin
        win.valid = 1'b1;
        win.idx   = IDX_W'(i);
        win.prio  = pri[i];
      end
    end
  end

  win_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    win.valid |-> active[win.idx] && pri[win.idx] == win.prio)
    else $error("winner is not an active source");
endmodule

// File: rtl/vpic_ctrl.sv
// Purpose: Vectored priority interrupt controller with APB registers
// Assumes: Sources and CPU signals on pclk; one external pin
// Notes:   Zero wait state APB, read data captured in setup phase
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module vpic_ctrl #(
  parameter logic [vpic_pkg::NUM_IRQ-1:0] VALID    = vpic_pkg::VALID_MASK,
  parameter logic [23:0]                  ALT_BASE = 24'h000114
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire vpic_pkg::vpic_addr_t          paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Event sources
  input  wire logic [vpic_pkg::NUM_IRQ-1:0]  src_event,
  input  wire logic                          external_irq_zero,
  input  wire logic [vpic_pkg::TRAP_W-1:0]   trap_event,
  input  wire logic [vpic_pkg::HTRAP_W-1:0]  hard_trap_event,
  // CPU core
  input  wire logic                          cpu_ack,
  input  wire logic                          cpu_return,
  output logic                               cpu_irq,
  output logic [7:0]                         cpu_vector_number,
  output logic [vpic_pkg::LVL_W-1:0]         cpu_new_level,
  output logic [23:0]                        cpu_vector_addr,
  output logic [vpic_pkg::LVL_W-1:0]         cpu_level
);
  import vpic_pkg::*;

  logic [NUM_IRQ-1:0]            flag;
  logic [NUM_IRQ-1:0]            en;
  logic [NUM_IRQ-1:0][PRI_W-1:0] pri;
  logic [NUM_IRQ-1:0]            set_vec;
  logic [NUM_IRQ-1:0]            active;
  logic                          nest_dis;
  logic [TRAP_W-1:0]             trap_flags;
  logic                          global_irq_enable;
  logic                          alternate_vector_table;
  logic [EDGE_W-1:0]             edge_sel;
  logic [HTRAP_W-1:0]            hard_flags;
  logic                          vhold;
  logic [7:0]                    pend_vec;
  logic [LVL_W-1:0]              pend_lvl;
  logic [PRI_W-1:0]              level_low;
  logic                          level_high;
  logic                          in_service;
  logic                          ext_pulse;
  logic                          request;
  logic                          wr_en;
  logic [9:0]                    widx;
  logic [15:0]                   rd;
  logic                          hit;

  vpic_win_if win ();

  ////////////////////////////////////////////////////////////////////////
  // External input and arbitration
  vpic_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (external_irq_zero),
    .falling (edge_sel[0]),
    .pulse   (ext_pulse)
  );

  assign set_vec = {src_event[NUM_IRQ-1:1], ext_pulse};
  assign active  = flag & en & VALID;

  vpic_arbiter u_arb (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (active),
    .pri     (pri),
    .win     (win)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  assign widx    = paddr[11:2];
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  ////////////////////////////////////////////////////////////////////////
  // Per-source flag, enable and priority
  for (genvar g = 0; g < NUM_IRQ; g++) begin : g_src
    localparam logic [9:0] FW = 10'(FLAG_OFF / 4 + g / 16);
    localparam logic [9:0] EW = 10'(EN_OFF / 4 + g / 16);
    localparam logic [9:0] PW = 10'(PRI_OFF / 4 + g / 4);
    localparam int         B  = g % 16;
    localparam int         P  = 4 * (g % 4);
    if (VALID[g]) begin : g_live
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          flag[g] <= 1'b0;
        else if (wr_en && widx == FW)
          flag[g] <= pwdata[B] | set_vec[g];
        else if (set_vec[g])
          flag[g] <= 1'b1;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          en[g] <= 1'b0;
        else if (wr_en && widx == EW)
          en[g] <= pwdata[B];
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pri[g] <= '0;
        else if (wr_en && widx == PW)
          pri[g] <= pwdata[P +: PRI_W];
      end
    end else begin : g_dead
      assign flag[g] = 1'b0;
      assign en[g]   = 1'b0;
      assign pri[g]  = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trap, global and hard trap registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_dis   <= 1'b0;
      trap_flags <= '0;
    end else if (wr_en && widx == TNC_OFF[11:2]) begin
      nest_dis   <= pwdata[NEST_DIS_BIT];
      trap_flags <= pwdata[TRAP_LSB +: TRAP_W] | trap_event;
    end else begin
      trap_flags <= trap_flags | trap_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable      <= GIC_RESET[GIE_BIT];
      alternate_vector_table     <= GIC_RESET[ALTERNATE_VECTOR_TABLE_BIT];
      edge_sel <= GIC_RESET[EDGE_W-1:0];
    end else if (wr_en && widx == GIC_OFF[11:2]) begin
      global_irq_enable      <= pwdata[GIE_BIT];
      alternate_vector_table     <= pwdata[ALTERNATE_VECTOR_TABLE_BIT];
      edge_sel <= pwdata[EDGE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hard_flags <= '0;
    else if (wr_en && widx == HTS_OFF[11:2])
      hard_flags <= (hard_flags & pwdata[HTRAP_W-1:0]) | hard_trap_event;
    else
      hard_flags <= hard_flags | hard_trap_event;
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU priority level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      level_low <= '0;
    else if (cpu_ack && cpu_irq)
      level_low <= cpu_new_level[PRI_W-1:0];
    else if (wr_en && widx == CSW_OFF[11:2] && !nest_dis)
      level_low <= pwdata[LVL_LSB +: PRI_W];
  end

  // High bit: set by traps, software may only clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      level_high <= 1'b0;
    else if ((|trap_event) || (|hard_trap_event))
      level_high <= 1'b1;
    else if (wr_en && widx == CORE_OFF[11:2] && !pwdata[LVL_HIGH_BIT])
      level_high <= 1'b0;
  end

  assign cpu_level = {level_high, level_low};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      in_service <= 1'b0;
    else if (cpu_ack && cpu_irq)
      in_service <= 1'b1;
    else if (cpu_return)
      in_service <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Request to the CPU
  always_comb begin
    request = win.valid && ({1'b0, win.prio} > cpu_level);
    if (!global_irq_enable) request = 1'b0;
    if (level_low == LVL_TOP) request = 1'b0;
    if (level_high) request = 1'b0;
    if (nest_dis && in_service) request = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cpu_irq <= 1'b0;
    else
      cpu_irq <= request && !(cpu_ack && cpu_irq);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_vector_number <= '0;
      cpu_new_level     <= '0;
      cpu_vector_addr   <= '0;
    end else if (!(cpu_ack && cpu_irq)) begin
      cpu_vector_number <= {1'b0, win.idx} + PENDING_VECTOR_NUMBER_OFS;
      cpu_new_level     <= {1'b0, win.prio};
      cpu_vector_addr   <= (alternate_vector_table ? ALT_BASE : VEC_BASE) + {16'h0, win.idx, 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending vector status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      vhold <= 1'b0;
    else if (wr_en && widx == PVS_OFF[11:2])
      vhold <= pwdata[VHOLD_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_vec <= '0;
      pend_lvl <= '0;
    end else if (vhold && win.valid) begin
      pend_vec <= {1'b0, win.idx} + PENDING_VECTOR_NUMBER_OFS;
      pend_lvl <= {1'b0, win.prio};
    end else if (!vhold && cpu_ack && cpu_irq) begin
      pend_vec <= cpu_vector_number;
      pend_lvl <= cpu_new_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd  = '0;
    hit = 1'b1;
    if (widx < 10'(FLAG_OFF / 4 + FLAG_REGS)) begin
      rd = flag[16 * widx[2:0] +: 16];
    end else if (widx >= EN_OFF[11:2] && widx < 10'(EN_OFF / 4 + FLAG_REGS)) begin
      rd = en[16 * widx[2:0] +: 16];
    end else if (widx >= PRI_OFF[11:2] && widx < 10'(PRI_OFF / 4 + PRI_REGS)) begin
      for (int j = 0; j < 4; j++)
        rd[4 * j +: PRI_W] = pri[4 * (widx - PRI_OFF[11:2]) + j];
    end else begin
      case (widx)
        TNC_OFF[11:2]: begin
          rd[NEST_DIS_BIT]             = nest_dis;
          rd[TRAP_LSB +: TRAP_W]       = trap_flags;
        end
        GIC_OFF[11:2]: begin
          rd[GIE_BIT]                  = global_irq_enable;
          rd[ALTERNATE_VECTOR_TABLE_BIT]                 = alternate_vector_table;
          rd[EDGE_W-1:0]               = edge_sel;
        end
        HTS_OFF[11:2]: rd[HTRAP_W-1:0] = hard_flags;
        PVS_OFF[11:2]: begin
          rd[CPUIRQ_BIT]               = cpu_irq;
          rd[VHOLD_BIT]                = vhold;
          rd[NEWLVL_LSB +: LVL_W]      = pend_lvl;
          rd[7:0]                      = pend_vec;
        end
        CSW_OFF[11:2]: rd[LVL_LSB +: PRI_W] = level_low;
        CORE_OFF[11:2]: rd[LVL_HIGH_BIT] = level_high;
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable)
      prdata <= {16'h0, rd};
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_unmapped;
    psel && !penable && !hit ##1 psel && penable;
  endsequence
  sequence s_ack;
    cpu_ack && cpu_irq;
  endsequence

  flag_set_a: assert property ((set_vec[NUM_IRQ-1] && VALID[NUM_IRQ-1]) ||
    (ext_pulse && VALID[0]) |=> flag[0] || flag[NUM_IRQ-1])
    else $error("event did not set its flag");
  flag_hold_a: assert property (!(wr_en && widx < 10'(FLAG_OFF / 4 + FLAG_REGS)) |=>
    ((flag & $past(flag)) == $past(flag)))
    else $error("flag cleared without software write");
  gie_gate_a: assert property (!global_irq_enable |=> !cpu_irq)
    else $error("request while global enable clear");
  low_top_a: assert property (level_low == LVL_TOP |=> !cpu_irq)
    else $error("request at level seven");
  high_block_a: assert property (level_high |=> !cpu_irq)
    else $error("request with high level bit set");
  level_lock_a: assert property (nest_dis && !cpu_ack && wr_en && widx == CSW_OFF[11:2]
    |=> $stable(level_low))
    else $error("level written while nesting disabled");
  nest_block_a: assert property (nest_dis && in_service |=> !cpu_irq)
    else $error("preemption with nesting disabled");
  prio_above_a: assert property (cpu_irq && !$past(cpu_ack) |->
    cpu_new_level > $past(cpu_level))
    else $error("request priority not above level");
  new_level_a: assert property (s_ack ##0 !vhold |=>
    pend_lvl == $past(cpu_new_level) && pend_vec == $past(cpu_vector_number))
    else $error("pending status not latched on acknowledge");
  unmapped_a: assert property (s_unmapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
endmodule

// File: rtl/vpic_edge_detect.sv
// Purpose: Synchronises an external pin and flags the chosen edge
// Assumes: Pin is asynchronous to pclk
// Notes:   One-cycle pulse output
`timescale 1ns/1ps
module vpic_edge_detect (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and control
  input  wire logic pin,
  input  wire logic falling,
  // Event
  output logic      pulse
);
  logic meta;
  logic sync;
  logic prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign pulse = falling ? (prev & ~sync) : (sync & ~prev);

  edge_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    pulse |-> (falling ? $fell(sync) : $rose(sync)))
    else $error("edge pulse of wrong polarity");
endmodule

// File: tb/tb.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero wait APB; CPU model acks every request
// Notes:   Register checks first, then source table, then hand-written cases
`timescale 1ns/1ps
module tb;
  import vpic_pkg::*;
  typedef struct {int irq; logic [23:0] va; int fr; int fb;} vpic_row_t;
  // Source number, vector address, flag register, flag bit
  vpic_row_t rows [14] = '{'{84, 24'h0000BC, 5, 4}, '{85, 24'h0000BE, 5, 5}, '{90, 24'h0000C8, 5, 10},
    '{91, 24'h0000CA, 5, 11}, '{94, 24'h0000D0, 5, 14}, '{95, 24'h0000D2, 5, 15}, '{96, 24'h0000D4, 6, 0},
    '{97, 24'h0000D6, 6, 1}, '{101, 24'h0000DE, 6, 5}, '{102, 24'h0000E0, 6, 6}, '{106, 24'h0000E8, 6, 10},
    '{108, 24'h0000EC, 6, 12}, '{110, 24'h0000F0, 6, 14}, '{117, 24'h0000FE, 7, 5}};
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic               external_irq_zero, cpu_irq, cpu_ack, cpu_return;
  vpic_addr_t         paddr;
  logic [31:0]        pwdata, prdata, q;
  logic [NUM_IRQ-1:0] src_event;
  logic [TRAP_W-1:0]  trap_event;
  logic [HTRAP_W-1:0] hard_trap_event;
  logic [7:0]         cpu_vector_number;
  logic [23:0]        cpu_vector_addr;
  logic [LVL_W-1:0]   cpu_new_level, cpu_level;
  logic [3:0]         ack_delay;
  int                 failures = 0, n_compared = 0, cyc = 0, a0;

  vpic_ctrl i_vpic_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .src_event, .external_irq_zero, .trap_event, .hard_trap_event, .cpu_ack, .cpu_return,
    .cpu_irq, .cpu_vector_number, .cpu_new_level, .cpu_vector_addr, .cpu_level);
  vpic_cpu_model i_vpic_cpu_model (.pclk, .presetn, .cpu_irq, .vec(cpu_vector_number),
    .addr(cpu_vector_addr), .lvl(cpu_new_level), .ack_delay, .cpu_ack, .cpu_return);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input vpic_addr_t a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Arm one source, raise its event, check request and flag, then clean up
  task automatic fire(input int n, input int fr, input int fb, input logic [23:0] va, input logic [2:0] p,
                      input bit e, input bit ex, input bit fl);
    a0 = i_vpic_cpu_model.n_acks;
    apb(1'b1, EN_OFF + 12'(4 * fr), 32'(e) << fb);
    apb(1'b1, PRI_OFF + 12'(4 * (n / 4)), 32'(p) << (4 * (n % 4)));
    @(posedge pclk);
    if (n == 0)
      external_irq_zero <= ~external_irq_zero;
    else
      src_event[n] <= 1'b1;
    @(posedge pclk);
    src_event <= '0;
    repeat (16) @(posedge pclk);
    chk("acks", 32'(a0 + int'(ex)), 32'(i_vpic_cpu_model.n_acks));
    if (ex) begin
      chk("vector", 32'(n + 8), 32'(i_vpic_cpu_model.seen_vec));
      chk("vaddr", 32'(va), 32'(i_vpic_cpu_model.seen_addr));
      chk("new level", 32'(p), 32'(i_vpic_cpu_model.seen_lvl));
      apb(1'b0, PVS_OFF, 32'h0);
      chk("pending", 32'(p) << 8 | 32'(n + 8), q & 32'h0000_0FFF);
    end
    apb(1'b0, FLAG_OFF + 12'(4 * fr), 32'h0);
    chk("flag", 32'(fl) << fb, q);
    apb(1'b1, FLAG_OFF + 12'(4 * fr), 32'h0);
    apb(1'b0, FLAG_OFF + 12'(4 * fr), 32'h0);
    chk("flag clear", 32'h0, q);
    apb(1'b1, EN_OFF + 12'(4 * fr), 32'h0);
    apb(1'b1, CSW_OFF, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    src_event = '0;
    external_irq_zero = 1'b0;
    trap_event = '0;
    hard_trap_event = '0;
    ack_delay = 4'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GIC_OFF, 32'h0);
    chk("gic reset", 32'h8000, q);
    chk("level reset", 32'h0, 32'(cpu_level));
    apb(1'b1, EN_OFF + 12'h014, 32'hFFFF);
    apb(1'b0, EN_OFF + 12'h014, 32'h0);
    chk("enable 5", 32'hCC30, q);
    apb(1'b1, PRI_OFF + 12'h054, 32'hFFFF);
    apb(1'b0, PRI_OFF + 12'h054, 32'h0);
    chk("prio 21", 32'h0077, q);
    apb(1'b1, CSW_OFF, 32'h00FF);
    apb(1'b0, CSW_OFF, 32'h0);
    chk("status word", 32'h00E0, q);
    apb(1'b1, CSW_OFF, 32'h0);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped", 32'h1, {31'h0, slv});
    foreach (rows[i]) begin
      ack_delay <= 4'(i % 2 * 5);
      fire(rows[i].irq, rows[i].fr, rows[i].fb, rows[i].va, 3'(i % 7 + 1), 1, 1, 1);
    end
    // Requests that must be held back
    fire(84, 5, 4, 24'h0000BC, 3'h3, 0, 0, 1);
    apb(1'b1, CSW_OFF, 32'h00A0);
    fire(84, 5, 4, 24'h0000BC, 3'h5, 1, 0, 1);
    apb(1'b1, CSW_OFF, 32'h00E0);
    fire(84, 5, 4, 24'h0000BC, 3'h7, 1, 0, 1);
    apb(1'b1, GIC_OFF, 32'h0);
    fire(84, 5, 4, 24'h0000BC, 3'h6, 1, 0, 1);
    apb(1'b1, GIC_OFF, 32'h8000);
    // Tie between equal priorities
    apb(1'b1, EN_OFF + 12'h014, 32'h0030);
    apb(1'b1, PRI_OFF + 12'h054, 32'h0044);
    a0 = i_vpic_cpu_model.n_acks;
    @(posedge pclk);
    src_event[85:84] <= 2'h3;
    @(posedge pclk);
    src_event <= '0;
    repeat (16) @(posedge pclk);
    chk("tie acks", 32'(a0 + 1), 32'(i_vpic_cpu_model.n_acks));
    chk("tie vector", 32'h5C, 32'(i_vpic_cpu_model.seen_vec));
    apb(1'b1, FLAG_OFF + 12'h014, 32'h0);
    fire(84, 5, 4, 24'h0000BC, 3'h0, 0, 0, 1);
    // Level bits locked while nesting is off
    apb(1'b1, TNC_OFF, 32'h8000);
    apb(1'b1, CSW_OFF, 32'h0060);
    apb(1'b0, CSW_OFF, 32'h0);
    chk("level locked", 32'h0, q);
    apb(1'b1, TNC_OFF, 32'h0);
    // Traps raise the high level bit
    @(posedge pclk);
    trap_event <= 4'h1;
    @(posedge pclk);
    trap_event <= 4'h0;
    apb(1'b0, TNC_OFF, 32'h0);
    chk("trap flag", 32'h0002, q);
    apb(1'b0, CORE_OFF, 32'h0);
    chk("high bit", 32'h0008, q);
    chk("level high", 32'h8, 32'(cpu_level));
    fire(84, 5, 4, 24'h0000BC, 3'h7, 1, 0, 1);
    apb(1'b1, CORE_OFF, 32'h0);
    apb(1'b1, CORE_OFF, 32'h0008);
    apb(1'b0, CORE_OFF, 32'h0);
    chk("high bit set", 32'h0, q);
    apb(1'b1, TNC_OFF, 32'h0);
    @(posedge pclk);
    hard_trap_event <= 2'h2;
    @(posedge pclk);
    hard_trap_event <= 2'h0;
    apb(1'b0, HTS_OFF, 32'h0);
    chk("hard trap", 32'h0002, q);
    apb(1'b1, HTS_OFF, 32'h0);
    apb(1'b0, HTS_OFF, 32'h0);
    chk("hard clear", 32'h0, q);
    apb(1'b1, CORE_OFF, 32'h0);
    // External pin edges under both selections
    fire(0, 0, 0, 24'h000014, 3'h4, 1, 1, 1);
    fire(0, 0, 0, 24'h000014, 3'h4, 1, 0, 0);
    apb(1'b1, GIC_OFF, 32'h8001);
    fire(0, 0, 0, 24'h000014, 3'h4, 1, 0, 0);
    fire(0, 0, 0, 24'h000014, 3'h4, 1, 1, 1);
    // Reset in mid-run restores defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GIC_OFF, 32'h0);
    chk("gic rereset", 32'h8000, q);
    chk("level rereset", 32'h0, 32'(cpu_level));
    stop_test();
  end
endmodule

// File: tb/vpic_cpu_model.sv
// Purpose: CPU core model that acknowledges and services requests
// Assumes: Same clock as the controller
// Notes:   Ack delay set by the bench; long service before return
`timescale 1ns/1ps
module vpic_cpu_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Controller side
  input  wire logic        cpu_irq,
  input  wire logic [7:0]  vec,
  input  wire logic [23:0] addr,
  input  wire logic [3:0]  lvl,
  input  wire logic [3:0]  ack_delay,
  output logic             cpu_ack,
  output logic             cpu_return
);
  logic [3:0]  wait_cnt;
  logic [5:0]  svc_cnt;
  int          n_acks;
  logic [7:0]  seen_vec;
  logic [23:0] seen_addr;
  logic [3:0]  seen_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      cpu_return <= 1'b0;
      wait_cnt <= 4'h0;
      svc_cnt <= 6'h00;
      n_acks <= 0;
    end else begin
      cpu_return <= (svc_cnt == 6'h01);
      if (svc_cnt != 6'h00)
        svc_cnt <= svc_cnt - 6'h01;
      if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_cnt <= 4'h0;
        // Vector values frozen at the ack edge
        if (cpu_irq) begin
          n_acks <= n_acks + 1;
          seen_vec <= vec;
          seen_addr <= addr;
          seen_lvl <= lvl;
          svc_cnt <= 6'h3F;
        end
      end else if (cpu_irq) begin
        if (wait_cnt == ack_delay)
          cpu_ack <= 1'b1;
        else
          wait_cnt <= wait_cnt + 4'h1;
      end else
        wait_cnt <= 4'h0;
    end
  end
endmodule
